// [src/fsb_cpu.sv]
// Processor end: frequency select, monitor outputs, request and data link.
`timescale 1ns/1ps
// Behaviour
// - breakpoint monitor outputs report each event, or a counter at all ones
// - priority request active stops new requests unless locked
// - priority agent holds request until done
// - select code for 667 MHz bus
// - all agents share one bus frequency
// - data path is 64 bits wide
// - data valid strobe marks each transfer
// - four data beats per bus clock
// - capture on falling edge of strobes
// - sixteen-bit lanes, own strobe pair each
module fsb_cpu #(
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  fsb_if.cpu bus,
  input wire logic [3:0] bpm_events,
  input wire logic req_valid,
  input wire logic req_locked,
  output logic req_ready,
  input wire logic [255:0] req_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [255:0] rx_data,
  output logic bus_owned
);
  typedef enum logic [3:0] {
    FSB_IDLE = 4'h1,
    FSB_ARB = 4'h2,
    FSB_SEND = 4'h4,
    FSB_DONE = 4'h8
  } fsb_state_t;

  fsb_state_t st_ff;
  logic [2:0] bclk_s;
  logic bclk_rise;
  logic [2:0] pri_s;
  logic pri_act;
  logic [2:0][3:0] sp_s;
  logic [2:0][3:0] sn_s;
  logic [2:0] vs_s;
  logic [1:0][63:0] dat_s;
  logic [3:0] bpm_ff;
  logic [15:0] cnt_ff [4];
  logic [1:0] tbeat_ff;
  logic [255:0] tsh_ff;
  logic [3:0] tstb_ff;
  logic tval_ff;
  logic [1:0] rbeat_ff;
  logic [255:0] racc_ff;
  logic [255:0] buf_ff [DEPTH];
  logic [$clog2(DEPTH):0] cnt_q_ff;
  logic wr_idx_ff, rd_idx_ff;
  logic full, empty, push;
  logic [3:0] fall;
  logic [63:0] lane_dat;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bclk_s <= 3'h0;
      pri_s <= 3'h0;
      sp_s <= '0;
      sn_s <= '0;
      vs_s <= 3'h0;
      dat_s <= '0;
    end else begin
      bclk_s <= {bclk_s[1:0], bus.bclk};
      pri_s <= {pri_s[1:0], bus.priority_bus_request};
      sp_s <= {sp_s[1:0], bus.data_strobe_positive};
      sn_s <= {sn_s[1:0], bus.data_strobe_negative};
      vs_s <= {vs_s[1:0], bus.data_valid_strobe & bus.drv_hub};
      // Data runs two stages behind, so a detected fall lines up with its word.
      dat_s <= {dat_s[0], bus.data_bus};
    end
  end
  assign bclk_rise = bclk_s[1] & ~bclk_s[2];
  assign pri_act = pri_s[1] & pri_s[2];

  assign bus.clock_freq_select = fsb_pkg::FREQ_SEL_667;

  genvar gi;
  generate
    for (gi = 0; gi < fsb_pkg::BPM_W; gi++) begin : g_bpm
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cnt_ff[gi] <= 16'h0;
          bpm_ff[gi] <= 1'b0;
        end else begin
          if (bpm_events[gi]) cnt_ff[gi] <= cnt_ff[gi] + 16'h1;
          bpm_ff[gi] <= bpm_events[gi] | (cnt_ff[gi] == 16'hFFFF);
        end
      end
    end
  endgenerate
  assign bus.breakpoint_monitor_out = bpm_ff;

  // no new request under priority unless locked.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= FSB_IDLE;
      tbeat_ff <= 2'h0;
      tsh_ff <= '0;
      tstb_ff <= 4'hF;
      tval_ff <= 1'b0;
    end else begin
      unique case (st_ff)
        FSB_IDLE: begin
          if (req_valid & (~pri_act | req_locked)) st_ff <= FSB_ARB;
        end
        FSB_ARB: begin
          if (pri_act & ~req_locked) begin
            st_ff <= FSB_IDLE;
          end else if (bclk_rise) begin
            st_ff <= FSB_SEND;
            tsh_ff <= req_data;
            tval_ff <= 1'b1;
            tbeat_ff <= 2'h0;
          end
        end
        FSB_SEND: begin
          // one beat per cycle, four total.
          tstb_ff <= tbeat_ff[0] ? 4'hF : 4'h0;
          tsh_ff <= {64'h0, tsh_ff[255:64]};
          tbeat_ff <= tbeat_ff + 2'h1;
          if (tbeat_ff == 2'h3) begin
            st_ff <= FSB_DONE;
            tval_ff <= 1'b0;
          end
        end
        FSB_DONE: begin
          tstb_ff <= 4'hF;
          st_ff <= FSB_IDLE;
        end
      endcase
    end
  end
  assign req_ready = (st_ff == FSB_ARB) & bclk_rise & ~(pri_act & ~req_locked);
  assign bus.symmetric_bus_request = (st_ff == FSB_ARB) | (st_ff == FSB_SEND);
  assign bus_owned = (st_ff == FSB_SEND);
  assign bus.drv_cpu = (st_ff == FSB_SEND) | (st_ff == FSB_DONE);
  assign bus.dat_cpu = tsh_ff[63:0];
  assign bus.inv_cpu = 4'h0;
  assign bus.valid_cpu = tval_ff;
  assign bus.stb_p_cpu = tstb_ff;
  assign bus.stb_n_cpu = ~tstb_ff | {4{st_ff != FSB_SEND}};

  // lane n owns its strobe pair.
  generate
    for (gi = 0; gi < fsb_pkg::LANES; gi++) begin : g_lane
      assign fall[gi] = (sp_s[2][gi] & ~sp_s[1][gi]) | (sn_s[2][gi] & ~sn_s[1][gi]);
      assign lane_dat[gi*16 +: 16] = dat_s[1][gi*16 +: 16];
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rbeat_ff <= 2'h0;
      racc_ff <= '0;
    end else if (vs_s[1] & (fall == 4'hF)) begin
      racc_ff <= {lane_dat, racc_ff[255:64]};
      rbeat_ff <= rbeat_ff + 2'h1;
    end
  end
  assign push = vs_s[1] & (fall == 4'hF) & (rbeat_ff == 2'h3);

  // Two-entry buffer; a full buffer drops the word since the link cannot stall.
  assign full = (cnt_q_ff == 2'(DEPTH));
  assign empty = (cnt_q_ff == 2'h0);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_idx_ff <= 1'b0;
      rd_idx_ff <= 1'b0;
      cnt_q_ff <= '0;
      for (int i = 0; i < DEPTH; i++) buf_ff[i] <= '0;
    end else begin
      if (push & ~full) begin
        buf_ff[wr_idx_ff] <= {lane_dat, racc_ff[255:64]};
        wr_idx_ff <= ~wr_idx_ff;
      end
      if (rx_ready & ~empty) rd_idx_ff <= ~rd_idx_ff;
      cnt_q_ff <= cnt_q_ff + 2'(push & ~full) - 2'(rx_ready & ~empty);
    end
  end
  assign rx_valid = ~empty;
  assign rx_data = buf_ff[rd_idx_ff];
endmodule

// [src/fsb_pkg.sv]
// Shared constants for both ends of the front side data link.
package fsb_pkg;
  localparam int DATA_W = 64;
  localparam int LANE_W = 16;
  localparam int LANES = 4;
  localparam int BEATS = 4;
  localparam int BPM_W = 4;
  localparam int SEL_W = 3;
  // Frequency select code for the 667 MHz bus with a 166 MHz clock.
  localparam logic [2:0] FREQ_SEL_667 = 3'h3;
  // Half the bus clock period in system clocks: the generated link clock toggles this often.
  localparam int BCLK_HALF = 4;
  localparam int CLK_NS = 50;
  localparam int SYNC_STAGES = 3;
endpackage

// [src/fsb_if.sv]
// Interface joining the processor end and the priority agent end.
`timescale 1ns/1ps
interface fsb_if;
  logic bclk;
  logic [2:0] clock_freq_select;
  logic priority_bus_request;
  logic symmetric_bus_request;
  logic [3:0] breakpoint_monitor_out;
  logic [63:0] dat_cpu;
  logic [63:0] dat_hub;
  logic [3:0] inv_cpu;
  logic [3:0] inv_hub;
  logic drv_cpu;
  logic drv_hub;
  logic [3:0] stb_p_cpu;
  logic [3:0] stb_n_cpu;
  logic [3:0] stb_p_hub;
  logic [3:0] stb_n_hub;
  logic valid_cpu;
  logic valid_hub;
  logic [63:0] data_bus;
  logic [3:0] polarity_inversion;
  logic [3:0] data_strobe_positive;
  logic [3:0] data_strobe_negative;
  logic data_valid_strobe;
  assign data_bus = drv_cpu ? dat_cpu : (drv_hub ? dat_hub : 64'h0);
  assign polarity_inversion = drv_cpu ? inv_cpu : (drv_hub ? inv_hub : 4'h0);
  assign data_strobe_positive = drv_cpu ? stb_p_cpu : (drv_hub ? stb_p_hub : 4'hF);
  assign data_strobe_negative = drv_cpu ? stb_n_cpu : (drv_hub ? stb_n_hub : 4'hF);
  assign data_valid_strobe = (drv_cpu & valid_cpu) | (drv_hub & valid_hub);
  modport cpu (
    input bclk, priority_bus_request, data_bus, polarity_inversion,
    input data_strobe_positive, data_strobe_negative, data_valid_strobe, drv_hub,
    output clock_freq_select, symmetric_bus_request, breakpoint_monitor_out,
    output dat_cpu, inv_cpu, drv_cpu, stb_p_cpu, stb_n_cpu, valid_cpu
  );
  modport hub (
    output bclk, priority_bus_request, dat_hub, inv_hub, drv_hub,
    output stb_p_hub, stb_n_hub, valid_hub,
    input clock_freq_select, symmetric_bus_request, breakpoint_monitor_out,
    input data_bus, polarity_inversion, data_strobe_positive, data_strobe_negative,
    input data_valid_strobe, drv_cpu
  );
endinterface

// [src/fsb_hub.sv]
// Priority agent end: makes the bus clock, arbitrates and moves data.
`timescale 1ns/1ps
module fsb_hub (
  input wire logic clk,
  input wire logic rst,
  fsb_if.hub bus,
  input wire logic pri_req,
  input wire logic pri_done,
  output logic pri_granted,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [255:0] tx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [255:0] rx_data,
  output logic [3:0] bpm_seen,
  output logic cpu_wants_bus
);
  logic [2:0] div_ff;
  logic bclk_ff;
  logic bclk_rise;
  logic pri_ff;
  logic [1:0] beat_ff;
  logic busy_ff;
  logic [255:0] sh_ff;
  logic [3:0] strobe_ff;
  logic valid_ff;
  logic drv_ff;
  logic [2:0][3:0] sp_s;
  logic [2:0][3:0] sn_s;
  logic [2:0] vs_s;
  logic [1:0] rbeat_ff;
  logic [255:0] racc_ff;
  logic [1:0][63:0] dat_s;
  logic cap;
  logic rpush;
  logic [255:0] rbuf_ff [2];
  logic rwr_ff;
  logic rrd_ff;
  logic [1:0] rcnt_ff;
  logic [3:0] bpm_s1, bpm_s2;
  logic sbr_s1, sbr_s2;

  // one common clock: the hub divides it out.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_ff <= 3'h0;
      bclk_ff <= 1'b0;
    end else if (div_ff == 3'(fsb_pkg::BCLK_HALF - 1)) begin
      div_ff <= 3'h0;
      bclk_ff <= ~bclk_ff;
    end else begin
      div_ff <= div_ff + 3'h1;
    end
  end
  assign bclk_rise = (div_ff == 3'(fsb_pkg::BCLK_HALF - 1)) & ~bclk_ff;
  assign bus.bclk = bclk_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pri_ff <= 1'b0;
    end else if (pri_req) begin
      pri_ff <= 1'b1;
    end else if (pri_done & ~busy_ff) begin
      pri_ff <= 1'b0;
    end
  end
  assign bus.priority_bus_request = pri_ff;
  assign pri_granted = pri_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_ff <= 1'b0;
      beat_ff <= 2'h0;
      sh_ff <= '0;
      strobe_ff <= 4'hF;
      valid_ff <= 1'b0;
    end else if (busy_ff) begin
      strobe_ff <= beat_ff[0] ? 4'hF : 4'h0;
      sh_ff <= {64'h0, sh_ff[255:64]};
      beat_ff <= beat_ff + 2'h1;
      if (beat_ff == 2'h3) begin
        busy_ff <= 1'b0;
        valid_ff <= 1'b0;
      end
    end else if (tx_valid & pri_ff & bclk_rise & ~bus.drv_cpu) begin
      busy_ff <= 1'b1;
      sh_ff <= tx_data;
      valid_ff <= 1'b1;
      beat_ff <= 2'h0;
      strobe_ff <= 4'hF;
    end
  end
  assign tx_ready = ~busy_ff & pri_ff & bclk_rise & ~bus.drv_cpu;
  assign bus.dat_hub = sh_ff[63:0];
  assign bus.inv_hub = 4'h0;
  assign bus.drv_hub = pri_ff & ~bus.drv_cpu;
  assign bus.valid_hub = valid_ff;
  assign bus.stb_p_hub = strobe_ff;
  assign bus.stb_n_hub = ~strobe_ff | {4{~busy_ff}};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sp_s <= '0;
      sn_s <= '0;
      vs_s <= '0;
      dat_s <= '0;
      bpm_s1 <= 4'h0;
      bpm_s2 <= 4'h0;
      sbr_s1 <= 1'b0;
      sbr_s2 <= 1'b0;
    end else begin
      sp_s <= {sp_s[1:0], bus.data_strobe_positive};
      sn_s <= {sn_s[1:0], bus.data_strobe_negative};
      vs_s <= {vs_s[1:0], bus.data_valid_strobe & bus.drv_cpu};
      // Data runs two stages behind, so a detected fall lines up with its word.
      dat_s <= {dat_s[0], bus.data_bus};
      bpm_s1 <= bus.breakpoint_monitor_out;
      bpm_s2 <= bpm_s1;
      sbr_s1 <= bus.symmetric_bus_request;
      sbr_s2 <= sbr_s1;
    end
  end
  assign bpm_seen = bpm_s2;
  assign cpu_wants_bus = sbr_s2;

  assign cap = vs_s[1] & (((sp_s[2] & ~sp_s[1]) | (sn_s[2] & ~sn_s[1])) == 4'hF);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rbeat_ff <= 2'h0;
      racc_ff <= '0;
    end else if (cap) begin
      racc_ff <= {dat_s[1], racc_ff[255:64]};
      rbeat_ff <= rbeat_ff + 2'h1;
    end
  end
  assign rpush = cap & (rbeat_ff == 2'h3);

  // Two-entry buffer: a stalled reader keeps two words; a third one is dropped.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rwr_ff <= 1'b0;
      rrd_ff <= 1'b0;
      rcnt_ff <= 2'h0;
      for (int i = 0; i < 2; i++) rbuf_ff[i] <= '0;
    end else begin
      if (rpush & (rcnt_ff != 2'h2)) begin
        rbuf_ff[rwr_ff] <= {dat_s[1], racc_ff[255:64]};
        rwr_ff <= ~rwr_ff;
      end
      if (rx_ready & (rcnt_ff != 2'h0)) rrd_ff <= ~rrd_ff;
      rcnt_ff <= rcnt_ff + 2'(rpush & (rcnt_ff != 2'h2)) - 2'(rx_ready & (rcnt_ff != 2'h0));
    end
  end
  assign rx_valid = (rcnt_ff != 2'h0);
  assign rx_data = rbuf_ff[rrd_ff];
endmodule

// [bench/fsb_link_checker.sv]
// Concurrent checks on the data link between the processor end and the hub end.
`timescale 1ns/1ps
module fsb_link_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic bclk,
  input wire logic [2:0] clock_freq_select,
  input wire logic priority_bus_request,
  input wire logic [3:0] polarity_inversion,
  input wire logic [3:0] data_strobe_positive,
  input wire logic [3:0] data_strobe_negative,
  input wire logic data_valid_strobe,
  input wire logic drv_cpu,
  input wire logic drv_hub
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_freq_code: assert property (clock_freq_select == fsb_pkg::FREQ_SEL_667)
    else $error("frequency select code wrong");
  a_bclk_period: assert property ($rose(bclk) |=> !$rose(bclk) [*7] ##1 $rose(bclk))
    else $error("bus clock period is not eight system clocks");
  a_one_driver: assert property (!(drv_cpu && drv_hub))
    else $error("both ends drive the data lines");
  a_valid_owner: assert property (data_valid_strobe |-> drv_cpu || drv_hub)
    else $error("valid strobe without a data driver");
  a_four_beats: assert property (
    $rose(data_valid_strobe) |-> data_valid_strobe [*4] ##1 !data_valid_strobe)
    else $error("transfer is not four beats long");
  a_strobe_step: assert property (
    data_valid_strobe && $past(data_valid_strobe) |->
      data_strobe_positive != $past(data_strobe_positive) ||
      data_strobe_negative != $past(data_strobe_negative))
    else $error("strobes did not move between beats");
  a_lane_strobes: assert property (
    data_valid_strobe |-> (data_strobe_positive == 4'h0 || data_strobe_positive == 4'hF) &&
      (data_strobe_negative == 4'h0 || data_strobe_negative == 4'hF))
    else $error("lane strobes out of step");
  a_no_inversion: assert property (polarity_inversion == 4'h0)
    else $error("polarity inversion used");
  c_cpu_send: cover property ($rose(data_valid_strobe) && drv_cpu);
  c_hub_send: cover property ($rose(data_valid_strobe) && drv_hub);
  c_priority: cover property ($rose(priority_bus_request));
endmodule

// [bench/tb.sv]
// Testbench joining both ends of the data link and checking traffic both ways.
`timescale 1ns/1ps
module tb;
  logic clk, rst, pri_req, pri_done, pri_granted, tx_valid, tx_ready, h_rx_valid, h_rx_ready;
  logic req_valid, req_locked, req_ready, c_rx_valid, c_rx_ready, bus_owned, cpu_wants_bus;
  logic [3:0] bpm_events, bpm_seen;
  logic [255:0] tx_data, req_data, h_rx_data, c_rx_data;
  int n_mismatch, samples_checked, i;
  fsb_if bus ();
  fsb_hub i_fsb_hub (.clk(clk), .rst(rst), .bus(bus), .pri_req(pri_req), .pri_done(pri_done),
    .pri_granted(pri_granted), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .rx_valid(h_rx_valid), .rx_ready(h_rx_ready), .rx_data(h_rx_data), .bpm_seen(bpm_seen),
    .cpu_wants_bus(cpu_wants_bus));
  fsb_cpu i_fsb_cpu (.clk(clk), .rst(rst), .bus(bus), .bpm_events(bpm_events),
    .req_valid(req_valid), .req_locked(req_locked), .req_ready(req_ready),
    .req_data(req_data), .rx_valid(c_rx_valid), .rx_ready(c_rx_ready), .rx_data(c_rx_data),
    .bus_owned(bus_owned));
  fsb_link_checker i_fsb_link_checker (.clk(clk), .rst(rst), .bclk(bus.bclk),
    .clock_freq_select(bus.clock_freq_select), .priority_bus_request(bus.priority_bus_request),
    .polarity_inversion(bus.polarity_inversion), .data_strobe_positive(bus.data_strobe_positive),
    .data_strobe_negative(bus.data_strobe_negative), .data_valid_strobe(bus.data_valid_strobe),
    .drv_cpu(bus.drv_cpu), .drv_hub(bus.drv_hub));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [255:0] exp, input logic [255:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic gave_up(input string what);
    n_mismatch++;
    $display("ERROR %s expected handshake seen none", what);
    summarize();
  endtask
  // Beats and lanes all differ, so a swap of either shows up in the data.
  function automatic logic [255:0] mk(input logic [7:0] k);
    return {4{64'h0123456789ABCDEF}} ^ {32{k}} ^ {64'h3, 64'h2, 64'h1, 64'h0};
  endfunction
  task automatic cpu_send(input logic [255:0] w);
    int j, n;
    logic [63:0] beat [4];
    n = 0;
    @(posedge clk);
    #2 req_data = w;
    req_valid = 1'b1;
    for (j = 0; j < 400 && req_ready !== 1'b1; j++) @(negedge clk);
    if (req_ready !== 1'b1) gave_up("req_ready");
    @(posedge clk);
    #2 req_valid = 1'b0;
    for (j = 0; j < 30; j++) begin
      @(negedge clk);
      if (j == 2) chk("bus request seen", 256'h3, {cpu_wants_bus, bus_owned});
      if (bus.data_valid_strobe === 1'b1 && bus.drv_cpu === 1'b1 && n < 4) begin
        beat[n] = bus.data_bus;
        n++;
      end
    end
    chk("beat count", 256'h4, n);
    for (j = 0; j < 4; j++) chk("wire beat", w[64*j+:64], beat[j]);
  endtask
  task automatic recv(input bit hub, input logic [255:0] w);
    int j;
    for (j = 0; j < 400; j++) begin
      @(negedge clk);
      if ((hub ? h_rx_valid : c_rx_valid) === 1'b1) break;
    end
    if (j == 400) gave_up("rx_valid");
    chk(hub ? "hub word" : "cpu word", w, hub ? h_rx_data : c_rx_data);
    @(posedge clk);
    #2 if (hub) h_rx_ready = 1'b1; else c_rx_ready = 1'b1;
    @(posedge clk);
    #2 h_rx_ready = 1'b0;
    c_rx_ready = 1'b0;
  endtask
  // The hub stalls while two words queue up, then drains them in order.
  task automatic t_cpu_to_hub();
    cpu_send(mk(8'h11));
    cpu_send(mk(8'h22));
    recv(1'b1, mk(8'h11));
    recv(1'b1, mk(8'h22));
  endtask
  // The hub sends only while it holds priority, then gives the bus back.
  task automatic t_hub_to_cpu();
    @(posedge clk);
    #2 pri_req = 1'b1;
    @(posedge clk);
    #2 pri_req = 1'b0;
    tx_data = mk(8'h33);
    tx_valid = 1'b1;
    for (i = 0; i < 400 && tx_ready !== 1'b1; i++) @(negedge clk);
    if (tx_ready !== 1'b1) gave_up("tx_ready");
    @(posedge clk);
    #2 tx_valid = 1'b0;
    recv(1'b0, mk(8'h33));
    @(posedge clk);
    #2 pri_done = 1'b1;
    @(posedge clk);
    #2 pri_done = 1'b0;
    chk("priority released", 256'h0, pri_granted);
  endtask
  task automatic t_priority();
    int seen;
    seen = 0;
    @(posedge clk);
    #2 pri_req = 1'b1;
    @(posedge clk);
    #2 pri_req = 1'b0;
    for (i = 0; i < 100 && pri_granted !== 1'b1; i++) @(negedge clk);
    if (pri_granted !== 1'b1) gave_up("pri_granted");
    // The processor end sees priority only after its synchroniser stages.
    repeat (4) @(posedge clk);
    #2 req_data = mk(8'h44);
    req_valid = 1'b1;
    for (i = 0; i < 60; i++) begin
      @(negedge clk);
      if (req_ready === 1'b1) seen++;
    end
    chk("refused word", 256'h0, seen);
    chk("priority held", 256'h1, bus.priority_bus_request);
    @(posedge clk);
    #2 pri_done = 1'b1;
    @(posedge clk);
    #2 pri_done = 1'b0;
    cpu_send(mk(8'h44));
    recv(1'b1, mk(8'h44));
  endtask
  task automatic t_monitor(input logic [3:0] v);
    @(posedge clk);
    #2 bpm_events = v;
    for (i = 0; i < 50 && bpm_seen !== v; i++) @(negedge clk);
    chk("monitor status", v, bpm_seen);
  endtask
  initial begin
    {pri_req, pri_done, tx_valid, h_rx_ready, req_valid, req_locked, c_rx_ready} = '0;
    bpm_events = 4'h0;
    tx_data = '0;
    req_data = '0;
    n_mismatch = 0;
    samples_checked = 0;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    #2 rst = 1'b0;
    chk("frequency select", fsb_pkg::FREQ_SEL_667, bus.clock_freq_select);
    t_cpu_to_hub();
    t_hub_to_cpu();
    t_priority();
    t_monitor(4'hA);
    t_monitor(4'h5);
    summarize();
  end
endmodule
